// ===== src/tas_pkg.sv
/*
 * tas_pkg: shared constants and types of the trigger arm sequencer.
 * Assumes a 20 MHz instrument clock and a plain register port.
 */
package tas_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_ARM_COUNT = 8'h04;
    localparam logic [7:0] ADDR_LINK_SEL = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_PASS = 8'h14;
    localparam logic [7:0] ADDR_MEAS_CFG = 8'h18;
    localparam logic [7:0] ADDR_MEAS_TIMER = 8'h1C;
    localparam logic [7:0] ADDR_MEAS_DELAY = 8'h20;
    localparam logic [7:0] ADDR_SCAN_CFG = 8'h24;
    localparam logic [7:0] ADDR_SCAN_TIMER = 8'h28;
    localparam logic [7:0] ADDR_SCAN_DELAY = 8'h2C;
    // control register fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_BYPASS = 3;
    localparam int CTRL_SINGLE = 4;
    localparam int CTRL_BURST = 5;
    localparam int CTRL_SCANHOLD = 6;
    localparam int CTRL_HALT = 7;
    // command register bits (write-only, self clearing)
    localparam int CMD_BUS_FRONT_TRIGGER_KEY = 0;
    localparam int CMD_PANEL_RST = 1;
    localparam int CMD_BUS_RST = 2;
    localparam int CMD_CLR_IGN = 3;
    // link select fields
    localparam int LSEL_IN_LSB = 0;
    localparam int LSEL_OUT_LSB = 4;
    // interval limits in milliseconds (0.001 s .. 999999.999 s)
    localparam logic [29:0] MS_MIN = 30'h0000_0001;
    localparam logic [29:0] MS_MAX = 30'h3B9A_C9FF;
    // reset values
    localparam logic [16:0] ARM_COUNT_RST = 17'h0_0001;
    // event sources
    typedef enum logic [2:0] {
        TAS_SRC_IMM = 3'b000,
        TAS_SRC_EXT = 3'b001,
        TAS_SRC_KEY = 3'b010,
        TAS_SRC_BUS = 3'b011,
        TAS_SRC_LINK = 3'b100,
        TAS_SRC_HOLD = 3'b101,
        TAS_SRC_TIMER = 3'b110
    } tas_src_t;
    // sequencer layers
    typedef enum logic [1:0] {
        TAS_IDLE = 2'b00,
        TAS_ARM = 2'b01,
        TAS_SCAN = 2'b10
    } tas_state_t;
endpackage

// ===== src/tas_top.sv
/*
 * tas_top: idle state and arm layer of a layered trigger sequencer,
 * plus storage of scan/measure layer options.
 * Assumes scan_done_i comes from logic on clk_i; trigger pins and the
 * front key are asynchronous and are synchronised here.
 */
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tas_top #(
    parameter int LINK_LINES = 6,
    parameter int CNT_W = 17
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // trigger pins, asynchronous
    input wire logic ext_front_trigger_key_n_i,
    input wire logic front_trigger_key_i,
    input wire logic [LINK_LINES-1:0] link_in_n_i,
    // trigger outputs
    output logic [LINK_LINES-1:0] link_out_o,
    output logic meter_complete_o,
    output logic front_trigger_key_ignored_o,
    // scan layer handoff
    output logic scan_start_o,
    input wire logic scan_done_i,
    // state and lower layer settings
    output logic armed_o,
    output logic [3:0] meas_cfg_o,
    output logic [29:0] meas_timer_o,
    output logic [29:0] meas_delay_o,
    output logic [3:0] scan_cfg_o,
    output logic [29:0] scan_timer_o,
    output logic [29:0] scan_delay_o
);

    localparam int NIN = LINK_LINES + 2;

    // elaboration check: count must hold 99999, link select is 3 bits
    if (CNT_W < 17 || CNT_W > 31 || LINK_LINES < 1 || LINK_LINES > 8)
    begin : g_bad_param
        $error("tas_top: unsupported parameter values");
    end

    ////////////////////////////////////////////////////////////////////
    // input synchronisers and edge detection
    ////////////////////////////////////////////////////////////////////
    logic [NIN-1:0] raw; // bit0 ext, bit1 key, rest link lines
    logic [NIN-1:0] sync1; // first stage, read only by sync2
    logic [NIN-1:0] sync2;
    logic [NIN-1:0] sync3;
    logic [NIN-1:0] filt; // accepted level
    logic [NIN-1:0] chg; // second and third agree on a new level

    assign raw = {link_in_n_i, front_trigger_key_i, ext_front_trigger_key_n_i};
    assign chg = ~(sync2 ^ sync3) & (sync3 ^ filt);

    // three flops; idle level is high for the low-true pins
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            sync1 <= {NIN{1'b1}} & ~{{(NIN-2){1'b0}}, 2'b10};
            sync2 <= {NIN{1'b1}} & ~{{(NIN-2){1'b0}}, 2'b10};
            sync3 <= {NIN{1'b1}} & ~{{(NIN-2){1'b0}}, 2'b10};
        end
        else
        begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // filtered level moves once per accepted change
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            filt <= {NIN{1'b1}} & ~{{(NIN-2){1'b0}}, 2'b10};
        else
            filt <= filt ^ chg;
    end

    ////////////////////////////////////////////////////////////////////
    // registers
    ////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl; // source, bypass, single, burst, scan hold, halt
    logic [CNT_W-1:0] arm_count; // zero means infinite
    logic [2:0] in_sel;
    logic [2:0] out_sel;
    logic ign_flag; // sticky trigger-ignored
    logic [CNT_W-1:0] passes;
    logic first_pass;
    tas_pkg::tas_src_t src;
    tas_pkg::tas_state_t state;
    logic wr_ctrl;
    logic wr_cmd;
    logic reset_cmd; // panel or bus reset command

    assign src = tas_pkg::tas_src_t'(ctrl[tas_pkg::CTRL_SRC_LSB +: 3]);
    assign wr_ctrl = wr_i && addr_i == tas_pkg::ADDR_CTRL;
    assign wr_cmd = wr_i && addr_i == tas_pkg::ADDR_CMD;
    assign reset_cmd = wr_cmd && (wdata_i[tas_pkg::CMD_PANEL_RST] ||
                                  wdata_i[tas_pkg::CMD_BUS_RST]);

    // clamp an interval to the legal millisecond range
    function automatic logic [29:0] clamp_ms(input logic [31:0] v);
        if (v < {2'b00, tas_pkg::MS_MIN})
            clamp_ms = tas_pkg::MS_MIN;
        else if (v > {2'b00, tas_pkg::MS_MAX})
            clamp_ms = tas_pkg::MS_MAX;
        else
            clamp_ms = v[29:0];
    endfunction

    // events derived from pins and the command register
    logic ext_ev;
    logic key_ev;
    logic link_ev;
    logic bus_ev;
    logic key_used; // key consumed to leave idle
    logic arm_hit;
    logic idle_exit;
    logic pass_last;
    logic halt_clr;

    assign ext_ev = chg[0] & ~sync3[0];
    assign key_ev = chg[1] & sync3[1];
    assign link_ev = chg[2 + 32'(in_sel)] & ~sync3[2 + 32'(in_sel)];
    assign bus_ev = wr_cmd && wdata_i[tas_pkg::CMD_BUS_FRONT_TRIGGER_KEY];

    // the arm event that lets operation pass into the scan layer
    always_comb
    begin
        case (src)
            tas_pkg::TAS_SRC_IMM: arm_hit = 1'b1;
            tas_pkg::TAS_SRC_EXT: arm_hit = ext_ev ||
                (ctrl[tas_pkg::CTRL_BYPASS] && first_pass);
            tas_pkg::TAS_SRC_KEY: arm_hit = key_ev;
            tas_pkg::TAS_SRC_BUS: arm_hit = bus_ev;
            tas_pkg::TAS_SRC_LINK: arm_hit = link_ev ||
                (ctrl[tas_pkg::CTRL_BYPASS] && first_pass);
            default: arm_hit = 1'b0;
        endcase
    end

    // leaving idle: blocked by scan hold, gated by key in halt/single/burst
    assign key_used = state == tas_pkg::TAS_IDLE && key_ev &&
        (ctrl[tas_pkg::CTRL_HALT] || ctrl[tas_pkg::CTRL_SINGLE] ||
         ctrl[tas_pkg::CTRL_BURST]);
    assign idle_exit = state == tas_pkg::TAS_IDLE &&
        !ctrl[tas_pkg::CTRL_SCANHOLD] &&
        (key_used || !(ctrl[tas_pkg::CTRL_HALT] ||
         ctrl[tas_pkg::CTRL_SINGLE] || ctrl[tas_pkg::CTRL_BURST]));
    assign halt_clr = key_used && ctrl[tas_pkg::CTRL_HALT];
    assign pass_last = ctrl[tas_pkg::CTRL_SINGLE] ||
        ctrl[tas_pkg::CTRL_BURST] ||
        (arm_count != '0 && passes + 1'b1 >= arm_count);

    // control register; reset commands restore the immediate source, only a bus reset sets single mode
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            ctrl <= 8'h00;
        else if (reset_cmd)
        begin
            ctrl <= 8'h00;
            ctrl[tas_pkg::CTRL_SINGLE] <= wdata_i[tas_pkg::CMD_BUS_RST];
        end
        else if (wr_ctrl)
            ctrl <= wdata_i[7:0]; // a written halt wins over the key
        else if (halt_clr)
            ctrl[tas_pkg::CTRL_HALT] <= 1'b0;
    end

    // arm count and link line selection
    always_ff @(posedge clk_i)
    begin
        if (reset_i || reset_cmd)
            arm_count <= CNT_W'(tas_pkg::ARM_COUNT_RST);
        else if (wr_i && addr_i == tas_pkg::ADDR_ARM_COUNT)
            arm_count <= (wdata_i > 32'd99999) ? CNT_W'(99999) :
                wdata_i[CNT_W-1:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            in_sel <= 3'h0;
            out_sel <= 3'h0;
        end
        else if (wr_i && addr_i == tas_pkg::ADDR_LINK_SEL)
        begin
            // out-of-range lines fall back to line zero
            in_sel <= (wdata_i[tas_pkg::LSEL_IN_LSB +: 3] < LINK_LINES) ?
                wdata_i[tas_pkg::LSEL_IN_LSB +: 3] : 3'h0;
            out_sel <= (wdata_i[tas_pkg::LSEL_OUT_LSB +: 3] < LINK_LINES) ?
                wdata_i[tas_pkg::LSEL_OUT_LSB +: 3] : 3'h0;
        end
    end

    // lower layer options, only stored and handed on
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            meas_cfg_o <= 4'h0;
            scan_cfg_o <= 4'h0;
            meas_timer_o <= tas_pkg::MS_MIN;
            meas_delay_o <= tas_pkg::MS_MIN;
            scan_timer_o <= tas_pkg::MS_MIN;
            scan_delay_o <= tas_pkg::MS_MIN;
        end
        else if (wr_i)
        begin
            case (addr_i)
                tas_pkg::ADDR_MEAS_CFG: meas_cfg_o <= wdata_i[3:0];
                tas_pkg::ADDR_MEAS_TIMER:
                    meas_timer_o <= clamp_ms(wdata_i);
                tas_pkg::ADDR_MEAS_DELAY:
                    meas_delay_o <= clamp_ms(wdata_i);
                tas_pkg::ADDR_SCAN_CFG: scan_cfg_o <= wdata_i[3:0];
                tas_pkg::ADDR_SCAN_TIMER:
                    scan_timer_o <= clamp_ms(wdata_i);
                tas_pkg::ADDR_SCAN_DELAY:
                    scan_delay_o <= clamp_ms(wdata_i);
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer
    ////////////////////////////////////////////////////////////////////
    // halt, scan hold and reset commands pull every layer back to idle;
    // a scan in flight is abandoned, its late done is ignored
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            state <= tas_pkg::TAS_IDLE;
        else if (ctrl[tas_pkg::CTRL_HALT] && !halt_clr ||
                 ctrl[tas_pkg::CTRL_SCANHOLD] || reset_cmd)
            state <= tas_pkg::TAS_IDLE;
        else
        begin
            case (state)
                tas_pkg::TAS_IDLE:
                    if (idle_exit)
                        state <= arm_hit ? tas_pkg::TAS_SCAN :
                            tas_pkg::TAS_ARM;
                tas_pkg::TAS_ARM:
                    if (arm_hit)
                        state <= tas_pkg::TAS_SCAN;
                tas_pkg::TAS_SCAN:
                    if (scan_done_i)
                        state <= pass_last ? tas_pkg::TAS_IDLE :
                            tas_pkg::TAS_ARM;
                default: state <= tas_pkg::TAS_IDLE;
            endcase
        end
    end

    // pass counter and bypass memory
    always_ff @(posedge clk_i)
    begin
        if (reset_i || state == tas_pkg::TAS_IDLE)
        begin
            passes <= '0;
            first_pass <= 1'b1;
        end
        else if (state == tas_pkg::TAS_SCAN && scan_done_i)
        begin
            passes <= passes + 1'b1;
            first_pass <= 1'b0;
        end
    end

    // scan start pulse on every entry into the scan layer
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            scan_start_o <= 1'b0;
        else
            scan_start_o <= !(ctrl[tas_pkg::CTRL_HALT] && !halt_clr) &&
                !ctrl[tas_pkg::CTRL_SCANHOLD] && !reset_cmd && arm_hit &&
                (idle_exit || state == tas_pkg::TAS_ARM);
    end

    // armed indicator
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            armed_o <= 1'b0;
        else
            armed_o <= state != tas_pkg::TAS_IDLE;
    end

    // output trigger on each scan return, only in bypass (source) mode
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            link_out_o <= '0;
            meter_complete_o <= 1'b0;
        end
        else
        begin
            link_out_o <= '0;
            meter_complete_o <= 1'b0;
            if (state == tas_pkg::TAS_SCAN && scan_done_i &&
                ctrl[tas_pkg::CTRL_BYPASS])
            begin
                if (src == tas_pkg::TAS_SRC_LINK)
                    link_out_o[out_sel] <= 1'b1;
                else
                    meter_complete_o <= 1'b1;
            end
        end
    end

    // ignored trigger: pulse out, sticky flag; a new event beats clear
    logic ign_ev;
    assign ign_ev = src == tas_pkg::TAS_SRC_IMM &&
        (ext_ev || (key_ev && !key_used));

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            front_trigger_key_ignored_o <= 1'b0;
            ign_flag <= 1'b0;
        end
        else
        begin
            front_trigger_key_ignored_o <= ign_ev;
            if (ign_ev)
                ign_flag <= 1'b1;
            else if (wr_cmd && wdata_i[tas_pkg::CMD_CLR_IGN])
                ign_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i)
    begin
        if (reset_i || !rd_i)
            rdata_o <= 32'h0000_0000;
        else
        begin
            case (addr_i)
                tas_pkg::ADDR_CTRL: rdata_o <= {24'h000000, ctrl};
                tas_pkg::ADDR_ARM_COUNT: rdata_o <= 32'(arm_count);
                tas_pkg::ADDR_LINK_SEL:
                    rdata_o <= {25'h0, out_sel, 1'b0, in_sel};
                tas_pkg::ADDR_STATUS:
                    rdata_o <= {27'h0, armed_o, first_pass, ign_flag, state};
                tas_pkg::ADDR_PASS: rdata_o <= 32'(passes);
                tas_pkg::ADDR_MEAS_CFG: rdata_o <= {28'h0, meas_cfg_o};
                tas_pkg::ADDR_MEAS_TIMER: rdata_o <= {2'b00, meas_timer_o};
                tas_pkg::ADDR_MEAS_DELAY: rdata_o <= {2'b00, meas_delay_o};
                tas_pkg::ADDR_SCAN_CFG: rdata_o <= {28'h0, scan_cfg_o};
                tas_pkg::ADDR_SCAN_TIMER: rdata_o <= {2'b00, scan_timer_o};
                tas_pkg::ADDR_SCAN_DELAY: rdata_o <= {2'b00, scan_delay_o};
                default: rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    a_idle_not_armed: assert property (
        state == tas_pkg::TAS_IDLE |=> !armed_o)
        else $error("armed while idle");
    a_hold_stays: assert property (
        state == tas_pkg::TAS_ARM && src == tas_pkg::TAS_SRC_HOLD &&
        !(wr_ctrl || reset_cmd) |=> state != tas_pkg::TAS_SCAN)
        else $error("hold source advanced");
    a_imm_direct: assert property (
        idle_exit && src == tas_pkg::TAS_SRC_IMM &&
        !ctrl[tas_pkg::CTRL_HALT] && !reset_cmd |=> state == tas_pkg::TAS_SCAN
        ##0 scan_start_o)
        else $error("immediate did not reach scan");
    a_ext_waits: assert property (
        state == tas_pkg::TAS_ARM && src == tas_pkg::TAS_SRC_EXT &&
        !first_pass && !ext_ev && !ctrl[tas_pkg::CTRL_HALT] &&
        !ctrl[tas_pkg::CTRL_SCANHOLD] && !reset_cmd
        |=> state == tas_pkg::TAS_ARM)
        else $error("external advanced without event");
    a_no_acceptor_out: assert property (
        !$past(ctrl[tas_pkg::CTRL_BYPASS]) |->
        !meter_complete_o && link_out_o == '0)
        else $error("acceptor mode pulsed output");
    a_bypass_out: assert property (
        state == tas_pkg::TAS_SCAN && scan_done_i &&
        ctrl[tas_pkg::CTRL_BYPASS] && src != tas_pkg::TAS_SRC_LINK
        |=> meter_complete_o)
        else $error("missing output trigger");
    a_ignored_flag: assert property (
        ign_ev |=> front_trigger_key_ignored_o && ign_flag)
        else $error("ignored trigger not flagged");
    a_reset_defaults: assert property (
        reset_cmd |=> src == tas_pkg::TAS_SRC_IMM &&
        arm_count == CNT_W'(1))
        else $error("reset command defaults wrong");
    a_count_one: assert property (
        state == tas_pkg::TAS_SCAN && scan_done_i &&
        arm_count == CNT_W'(1) && !ctrl[tas_pkg::CTRL_HALT] &&
        !ctrl[tas_pkg::CTRL_SCANHOLD] |=> state == tas_pkg::TAS_IDLE)
        else $error("count one did not end");

endmodule
`default_nettype wire

// ===== verification/tas_scan_model.sv
/*
 * tas_scan_model: stand-in for the scan layer below the arm layer.
 * Assumes scan_start_i is a one-cycle pulse on clk_i; answers with one
 * scan_done_o pulse a fixed number of cycles later.
 */
`timescale 1ns/1ps
`default_nettype none
module tas_scan_model #(
    parameter int DELAY = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // handoff with the arm layer
    input wire logic scan_start_i,
    output logic scan_done_o
);
    // cycles left until the scan completes, 0 when no scan is running
    int left;
    ////////////////////////////////////////////////////////////////////
    // one done per start; a start while busy restarts the scan
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            left <= 0;
            scan_done_o <= 1'b0;
        end
        else
        begin
            scan_done_o <= (left == 1);
            if (scan_start_i)
                left <= DELAY;
            else if (left != 0)
                left <= left - 1;
        end
    end
endmodule
`default_nettype wire

// ===== verification/tas_top_bench.sv
/*
 * tas_top_bench: directed tests of the arm layer sequencer.
 * Assumes the scan layer model answers every scan start.
 */
`timescale 1ns/1ps
`default_nettype none
module tas_top_bench;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [31:0] rdata_o;
    logic ext_front_trigger_key_n_i = 1'b1;
    logic front_trigger_key_i = 1'b0;
    logic [5:0] link_in_n_i = 6'h3F;
    logic [5:0] link_out_o;
    logic meter_complete_o, front_trigger_key_ignored_o, scan_start_o, scan_done_i;
    logic armed_o;
    logic [3:0] meas_cfg_o, scan_cfg_o;
    logic [29:0] meas_timer_o, meas_delay_o, scan_timer_o, scan_delay_o;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    // pulse counters, cleared at the start of each observation window
    int n_start, n_meter, n_ign, n_link, n_lbad;
    logic [31:0] d;
    ////////////////////////////////////////////////////////////////////
    tas_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .ext_front_trigger_key_n_i(ext_front_trigger_key_n_i),
        .front_trigger_key_i(front_trigger_key_i),
        .link_in_n_i(link_in_n_i), .link_out_o(link_out_o),
        .meter_complete_o(meter_complete_o),
        .front_trigger_key_ignored_o(front_trigger_key_ignored_o), .scan_start_o(scan_start_o),
        .scan_done_i(scan_done_i), .armed_o(armed_o),
        .meas_cfg_o(meas_cfg_o), .meas_timer_o(meas_timer_o),
        .meas_delay_o(meas_delay_o), .scan_cfg_o(scan_cfg_o),
        .scan_timer_o(scan_timer_o), .scan_delay_o(scan_delay_o));
    tas_scan_model u_scan (.clk_i(clk_i), .reset_i(reset_i),
        .scan_start_i(scan_start_o), .scan_done_o(scan_done_i));
    ////////////////////////////////////////////////////////////////////
    // 50 ns clock; counters and hang guard
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc++;
        n_start += (scan_start_o === 1'b1);
        n_meter += (meter_complete_o === 1'b1);
        n_ign += (front_trigger_key_ignored_o === 1'b1);
        n_link += (link_out_o === 6'h08);
        n_lbad += (link_out_o !== 6'h08 && link_out_o !== 6'h00);
        if (cyc == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic clr();
        #1 {n_start, n_meter, n_ign, n_link, n_lbad} = '0;
    endtask
    // pins are held long enough for the synchroniser to see them
    task automatic key();
        front_trigger_key_i <= 1'b1;
        cyc_wait(6);
        front_trigger_key_i <= 1'b0;
        cyc_wait(6);
    endtask
    task automatic ext();
        ext_front_trigger_key_n_i <= 1'b0;
        cyc_wait(6);
        ext_front_trigger_key_n_i <= 1'b1;
        cyc_wait(6);
    endtask
    // park in idle with halt, then leave it with a key press
    task automatic cfg(input logic [7:0] ctrl, input logic [31:0] cnt);
        wr(tas_pkg::ADDR_ARM_COUNT, cnt);
        wr(tas_pkg::ADDR_CTRL, {24'h0, ctrl | 8'h80});
        cyc_wait(10);
        clr();
        key();
        cyc_wait(20);
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_halt();
        wr(tas_pkg::ADDR_CTRL, 32'h80);
        cyc_wait(5);
        rd(tas_pkg::ADDR_STATUS, d);
        chk(d & 32'h13, 32'h0, "idle, not armed");
        clr();
        cyc_wait(20);
        chk(n_start, 0, "no scan in halt");
        key();
        cyc_wait(10);
        chk(n_start != 0, 1, "key resumes");
        done("halt");
    endtask
    task automatic t_settings();
        rd(tas_pkg::ADDR_ARM_COUNT, d);
        chk(d, 32'h1, "count reset");
        wr(tas_pkg::ADDR_ARM_COUNT, 32'h0003_0D40);
        rd(tas_pkg::ADDR_ARM_COUNT, d);
        chk(d, 32'h0001_869F, "count clamp");
        wr(tas_pkg::ADDR_MEAS_TIMER, 32'h0);
        wr(tas_pkg::ADDR_SCAN_DELAY, 32'hFFFF_FFFF);
        wr(tas_pkg::ADDR_SCAN_CFG, 32'hE);
        cyc_wait(2);
        chk(meas_timer_o, 30'h1, "timer min");
        chk(scan_delay_o, tas_pkg::MS_MAX, "delay max");
        chk(scan_cfg_o, 4'hE, "scan timer source");
        chk(meas_delay_o, tas_pkg::MS_MIN, "meas delay reset");
        chk(scan_timer_o, tas_pkg::MS_MIN, "scan timer reset");
        chk(meas_cfg_o, 4'h0, "meas source reset");
        rd(8'hFF, d);
        chk(d, 32'h0, "unmapped read");
        done("settings");
    endtask
    task automatic t_ignored();
        wr(tas_pkg::ADDR_CMD, 32'h8);
        wr(tas_pkg::ADDR_CTRL, 32'h0);
        cyc_wait(5);
        clr();
        ext();
        chk(n_ign, 1, "ext ignored");
        rd(tas_pkg::ADDR_STATUS, d);
        chk(d[2], 1'b1, "ignored flag");
        done("ignored");
    endtask
    task automatic t_ext_bypass();
        cfg(8'h09, 32'h2);
        chk(n_start, 1, "first pass bypassed");
        chk(n_meter, 1, "output on complete");
        cyc_wait(20);
        chk(n_start, 1, "repeat waits");
        ext();
        cyc_wait(30);
        chk(n_start, 3, "ext arms, bypass again");
        chk(n_meter, 3, "pulse per return");
        done("ext_bypass");
    endtask
    task automatic t_link();
        wr(tas_pkg::ADDR_LINK_SEL, 32'h32);
        cfg(8'h0C, 32'h2);
        chk(n_start, 1, "link bypass");
        link_in_n_i[2] <= 1'b0;
        cyc_wait(6);
        link_in_n_i[2] <= 1'b1;
        cyc_wait(36);
        chk(n_start, 3, "link arms");
        chk(n_link, 3, "link out line");
        chk(n_meter + n_lbad, 0, "no other output");
        done("link");
    endtask
    task automatic t_bus();
        cfg(8'h03, 32'h1);
        chk(n_start, 0, "bus waits");
        wr(tas_pkg::ADDR_CMD, 32'h1);
        cyc_wait(30);
        chk(n_start, 1, "bus trigger arms");
        chk(n_meter + n_link, 0, "acceptor silent");
        done("bus");
    endtask
    task automatic t_hold();
        cfg(8'h05, 32'h1);
        ext();
        wr(tas_pkg::ADDR_CMD, 32'h1);
        cyc_wait(20);
        chk(n_start, 0, "hold ignores all");
        done("hold");
    endtask
    task automatic t_single();
        wr(tas_pkg::ADDR_CMD, 32'h4);
        clr();
        cyc_wait(30);
        chk(n_start, 0, "single idles");
        key();
        cyc_wait(30);
        chk(n_start, 1, "one reading per key");
        rd(tas_pkg::ADDR_STATUS, d);
        chk(d & 32'h13, 32'h0, "back to idle");
        chk(armed_o, 1'b0, "armed off in idle");
        done("single");
    endtask
    // panel reset, then burst mode and scan configuration hold idle
    task automatic t_burst();
        wr(tas_pkg::ADDR_ARM_COUNT, 32'h5);
        wr(tas_pkg::ADDR_CMD, 32'h2);
        rd(tas_pkg::ADDR_ARM_COUNT, d);
        chk(d, 32'h1, "panel reset count");
        rd(tas_pkg::ADDR_CTRL, d);
        chk(d, 32'h0, "panel reset source");
        wr(tas_pkg::ADDR_CTRL, 32'h20);
        cyc_wait(10);
        clr();
        cyc_wait(20);
        chk(n_start, 0, "burst idles");
        key();
        cyc_wait(20);
        chk(n_start, 1, "one burst per key");
        wr(tas_pkg::ADDR_CTRL, 32'h40);
        clr();
        cyc_wait(20);
        chk(n_start, 0, "scan config holds idle");
        wr(tas_pkg::ADDR_CTRL, 32'h0);
        cyc_wait(20);
        chk(n_start != 0, 1, "scan off resumes");
        done("burst");
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        cyc_wait(5);
        reset_i <= 1'b0;
        cyc_wait(3);
        t_halt();
        t_settings();
        t_ignored();
        t_ext_bypass();
        t_link();
        t_bus();
        t_hold();
        t_single();
        t_burst();
        end_of_test();
    end
endmodule
`default_nettype wire
